// ---- hdl/atads_pkg.sv ----
package atads_pkg;
   // Ultra DMA direction as seen by the host
   typedef enum logic [1:0] {
      ATADS_IDLE,
      ATADS_UDMA_IN,
      ATADS_UDMA_OUT
   } atads_mode_e;
   localparam logic RESET_STROBE = 1'b0;
   localparam logic RESET_IRQ = 1'b0;
   localparam int SYNC_STAGES = 2;
   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage : atads_pkg

// ---- hdl/atads_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module atads_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } atads_sync_s;
   atads_sync_s state_reg;
   atads_sync_s state_next;
   always_comb begin
      state_next.stage1 = asyncIn;
      state_next.stage2 = state_reg.stage1;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign syncOut = state_reg.stage2;
endmodule : atads_sync
`default_nettype wire

// ---- hdl/atads_strobe.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Outside Ultra DMA a write-strobe edge from the host captures the data bus.
// - During Ultra DMA the write-strobe line means stop and ends the current burst.
// - In PIO mode the ready line stays asserted and never stretches a cycle.
// - In a data-out burst the device asserts its ready on the ready line when it can take data.
// - The device may drop its ready to pause a data-out burst until asserted again.
// - In a data-in burst the device toggles the strobe, one word per rising or falling edge.
// - The device pauses a data-in burst by holding the strobe at its level.
// - The word-transfer output is driven low during every 16-bit transfer cycle.
// - The interrupt output is high when an interrupt is pending, low otherwise.
// - While the host reset input is low the block stays in its reset state.
// - The pass-diagnostic pin is two-way in the master/slave handshake.
// - The drive-active/slave-present pin is two-way in the master/slave handshake.
// - In a data-out burst both edges of the host strobe on the read line latch a word.
// - A grounded cable-select makes the device master, open makes it slave, caught once after reset.
module atads_strobe (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hostReset_b,
   input wire logic ioWrite_b,
   input wire logic ioRead_b,
   input wire logic [15:0] dataIn,
   input wire logic cableSel,
   input wire logic udmaIn,
   input wire logic udmaOut,
   input wire logic wordCycle,
   input wire logic irqPending,
   input wire logic outReady,
   input wire logic [15:0] sendWord,
   input wire logic sendValid,
   output logic sendTaken,
   input wire logic diagDrive,
   input wire logic activeDrive,
   input wire logic diagIn,
   input wire logic activeIn,
   output logic [15:0] dataOut,
   output logic dataOutEn_b,
   output logic ioReady,
   output logic ioCs16_b,
   output logic intRq,
   output logic diagOut,
   output logic diagEn_b,
   output logic activeOut,
   output logic activeEn_b,
   output logic diagSeen,
   output logic activeSeen,
   output logic isMaster,
   output logic [15:0] capWord,
   output logic capValid,
   output logic burstStop,
   output logic [15:0] inWord,
   output logic inValid
);
   typedef struct packed {
      logic [1:0] settle;
      logic strapDone;
      logic master;
      logic wrLast;
      logic rdLast;
      logic stopLast;
      logic dStrobe;
      logic [15:0] word;
      logic [15:0] cap;
      logic capV;
      logic stop;
      logic [15:0] inW;
      logic inV;
      logic irq;
      logic cs16;
   } atads_strobe_s;
   atads_strobe_s state_reg;
   atads_strobe_s state_next;
   logic [5:0] pinSync;
   logic wrS;
   logic rdS;
   logic csS;
   logic hrS;
   logic dgS;
   logic acS;
   logic rstInt;
   logic synced;
   atads_pkg::atads_mode_e mode;
   localparam logic [1:0] SETTLE_DONE = 2'(atads_pkg::SYNC_STAGES + 1);
   atads_sync #(.WIDTH(6)) uSync (
      .mclk(mclk),
      .rst_b(rst_b),
      .asyncIn({ioWrite_b, ioRead_b, cableSel, hostReset_b, diagIn, activeIn}),
      .syncOut(pinSync)
   );
   assign {wrS, rdS, csS, hrS, dgS, acS} = pinSync;
   // Host reset is held as a synchronous clear so pin glitches stay timed
   // Also held until the synchroniser shows real pin levels, else its reset value looks like an edge
   assign synced = (state_reg.settle == SETTLE_DONE);
   assign rstInt = !hrS || !synced;
   assign mode = udmaIn ? atads_pkg::ATADS_UDMA_IN :
                 (udmaOut ? atads_pkg::ATADS_UDMA_OUT : atads_pkg::ATADS_IDLE);
   // Data-in words advance on each toggle, only while host ready is low
   assign sendTaken = (mode == atads_pkg::ATADS_UDMA_IN) && sendValid && !rdS && !rstInt;
   always_comb begin
      state_next = state_reg;
      state_next.wrLast = wrS;
      state_next.rdLast = rdS;
      state_next.stopLast = wrS;
      state_next.capV = 1'b0;
      state_next.stop = 1'b0;
      state_next.inV = 1'b0;
      if (mode == atads_pkg::ATADS_IDLE) begin
         if (!state_reg.wrLast && wrS) begin
            state_next.cap = dataIn;
            state_next.capV = 1'b1;
         end
      end else if (!state_reg.stopLast && wrS) begin
         state_next.stop = 1'b1;
      end
      if (mode == atads_pkg::ATADS_UDMA_OUT && state_reg.rdLast != rdS) begin
         state_next.inW = dataIn;
         state_next.inV = 1'b1;
      end
      if (sendTaken) begin
         state_next.dStrobe = !state_reg.dStrobe;
         state_next.word = sendWord;
      end
      // No toggle leaves the strobe at its level for a pause
      if (mode != atads_pkg::ATADS_UDMA_IN) begin
         state_next.dStrobe = atads_pkg::RESET_STROBE;
      end
      state_next.irq = irqPending;
      state_next.cs16 = wordCycle;
      if (rstInt) begin
         state_next = '0;
         state_next.strapDone = state_reg.strapDone;
         state_next.master = state_reg.master;
         state_next.wrLast = wrS;
         state_next.rdLast = rdS;
         state_next.stopLast = wrS;
      end
      if (!synced) begin
         state_next.settle = state_reg.settle + 2'h1;
      end else begin
         state_next.settle = state_reg.settle;
      end
      // Strap caught once, only when the synchroniser holds the real pin level
      if (synced && !state_reg.strapDone) begin
         state_next.strapDone = 1'b1;
         state_next.master = !csS;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   always_comb begin
      case (mode)
         atads_pkg::ATADS_UDMA_IN: ioReady = state_reg.dStrobe;
         atads_pkg::ATADS_UDMA_OUT: ioReady = !outReady;
         default: ioReady = 1'b1;
      endcase
   end
   assign dataOut = state_reg.word;
   assign dataOutEn_b = !(mode == atads_pkg::ATADS_UDMA_IN);
   assign ioCs16_b = !state_reg.cs16;
   assign intRq = state_reg.irq;
   assign diagOut = 1'b0;
   assign diagEn_b = !diagDrive;
   assign activeOut = 1'b0;
   assign activeEn_b = !activeDrive;
   assign diagSeen = synced && !dgS;
   assign activeSeen = synced && !acS;
   assign isMaster = state_reg.master;
   assign capWord = state_reg.cap;
   assign capValid = state_reg.capV;
   assign burstStop = state_reg.stop;
   assign inWord = state_reg.inW;
   assign inValid = state_reg.inV;

   chk_pio_ready: assert property (@(posedge mclk) disable iff (!rst_b)
      (!udmaIn && !udmaOut) |-> ioReady)
      else $error("ready low in PIO");
   chk_out_ready: assert property (@(posedge mclk) disable iff (!rst_b)
      (udmaOut && !udmaIn) |-> (ioReady == !outReady))
      else $error("ready wrong in data-out");
   chk_strobe_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      ((udmaIn && !sendTaken && !rstInt) ##1 udmaIn) |-> $stable(ioReady))
      else $error("strobe moved in pause");
   chk_strobe_toggle: assert property (@(posedge mclk) disable iff (!rst_b)
      (sendTaken ##1 udmaIn) |-> (ioReady != $past(ioReady)))
      else $error("strobe missed toggle");
   chk_in_word: assert property (@(posedge mclk) disable iff (!rst_b)
      sendTaken |=> (dataOut == $past(sendWord)))
      else $error("data-in word not shown");
   chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (intRq == ($past(irqPending) && !$past(rstInt))))
      else $error("irq level wrong");
   chk_cs16_word: assert property (@(posedge mclk) disable iff (!rst_b)
      (wordCycle && !rstInt) |=> !ioCs16_b)
      else $error("word cycle not flagged");
   chk_reset_clear: assert property (@(posedge mclk) disable iff (!rst_b)
      rstInt |=> (!intRq && !capValid && !burstStop))
      else $error("host reset ignored");
   chk_stop_pio: assert property (@(posedge mclk) disable iff (!rst_b)
      (!udmaIn && !udmaOut) |=> !burstStop)
      else $error("stop outside burst");

   // A data-out word takes two steps: the synced strobe edge, then the latched word
   sequence seq_out_edge;
      (mode == atads_pkg::ATADS_UDMA_OUT) && !rstInt && (rdS != state_reg.rdLast);
   endsequence
   sequence seq_word_latched;
      inValid && (inWord == $past(dataIn));
   endsequence
   chk_hstrobe_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      seq_out_edge |=> seq_word_latched)
      else $error("data-out word missed");
   sequence seq_stop_edge;
      (mode != atads_pkg::ATADS_IDLE) && !rstInt && !state_reg.stopLast && wrS;
   endsequence
   chk_stop_burst: assert property (@(posedge mclk) disable iff (!rst_b)
      seq_stop_edge |=> (burstStop && !capValid))
      else $error("stop not raised");
   chk_pio_capture: assert property (@(posedge mclk) disable iff (!rst_b)
      ((mode == atads_pkg::ATADS_IDLE) && !rstInt && !state_reg.wrLast && wrS)
      |=> (capValid && (capWord == $past(dataIn))))
      else $error("write word missed");
   chk_strap_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      state_reg.strapDone |=> (isMaster == $past(isMaster)))
      else $error("strap changed");
endmodule : atads_strobe
`default_nettype wire

// ---- bench/atads_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module atads_host (
   input wire logic mclk,
   output logic hostReset_b,
   output logic ioWrite_b,
   output logic ioRead_b,
   output logic [15:0] dataIn
);
   initial begin
      hostReset_b = 1'b1;
      ioWrite_b = 1'b1;
      ioRead_b = 1'b1;
      dataIn = 16'h0000;
   end
   // Half a link period of 80 ns
   task automatic half;
      repeat (4) @(posedge mclk);
   endtask : half
   task automatic pio_write(input logic [15:0] d);
      @(posedge mclk);
      dataIn <= d;
      ioWrite_b <= 1'b0;
      half();
      ioWrite_b <= 1'b1;
      half();
      dataIn <= ~d; // Released bus no longer shows the word
   endtask : pio_write
   task automatic hstrobe(input logic [15:0] d);
      @(posedge mclk);
      dataIn <= d;
      ioRead_b <= ~ioRead_b;
      half();
   endtask : hstrobe
   task automatic stop;
      @(posedge mclk);
      ioWrite_b <= 1'b0;
      half();
      ioWrite_b <= 1'b1;
      half();
   endtask : stop
   task automatic ready(input logic v);
      @(posedge mclk);
      ioRead_b <= ~v;
   endtask : ready
   task automatic hreset(input logic v);
      @(posedge mclk);
      hostReset_b <= v;
   endtask : hreset
endmodule : atads_host
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
   logic mclk, rst_b, hostReset_b, ioWrite_b, ioRead_b, cableSel, udmaIn, udmaOut, wordCycle, irqPending;
   logic outReady, sendValid, sendTaken, diagDrive, activeDrive, diagIn, activeIn, dataOutEn_b, ioReady;
   logic ioCs16_b, intRq, diagOut, diagEn_b, activeOut, activeEn_b, diagSeen, activeSeen, isMaster;
   logic capValid, burstStop, inValid, s;
   logic [15:0] dataIn, sendWord, dataOut, capWord, inWord;
   int fails = 0, compares = 0, caps = 0, stops = 0, ins = 0, c0;
   atads_strobe uut (
      .mclk(mclk),
      .rst_b(rst_b),
      .hostReset_b(hostReset_b),
      .ioWrite_b(ioWrite_b),
      .ioRead_b(ioRead_b),
      .dataIn(dataIn),
      .cableSel(cableSel),
      .udmaIn(udmaIn),
      .udmaOut(udmaOut),
      .wordCycle(wordCycle),
      .irqPending(irqPending),
      .outReady(outReady),
      .sendWord(sendWord),
      .sendValid(sendValid),
      .sendTaken(sendTaken),
      .diagDrive(diagDrive),
      .activeDrive(activeDrive),
      .diagIn(diagIn),
      .activeIn(activeIn),
      .dataOut(dataOut),
      .dataOutEn_b(dataOutEn_b),
      .ioReady(ioReady),
      .ioCs16_b(ioCs16_b),
      .intRq(intRq),
      .diagOut(diagOut),
      .diagEn_b(diagEn_b),
      .activeOut(activeOut),
      .activeEn_b(activeEn_b),
      .diagSeen(diagSeen),
      .activeSeen(activeSeen),
      .isMaster(isMaster),
      .capWord(capWord),
      .capValid(capValid),
      .burstStop(burstStop),
      .inWord(inWord),
      .inValid(inValid)
   );
   atads_host host (
      .mclk(mclk),
      .hostReset_b(hostReset_b),
      .ioWrite_b(ioWrite_b),
      .ioRead_b(ioRead_b),
      .dataIn(dataIn)
   );
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (capValid === 1'b1) caps++;
      if (burstStop === 1'b1) stops++;
      if (inValid === 1'b1) ins++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic t_pio;
      host.pio_write(16'hA55A);
      @(negedge mclk);
      `CHK("capWord", 16'hA55A, capWord)
      `CHK("caps", 1, caps)
      `CHK("ioReady", 1'b1, ioReady)
      tick(1);
      wordCycle <= 1'b1;
      irqPending <= 1'b1;
      tick(3);
      @(negedge mclk);
      `CHK("ioCs16_b", 1'b0, ioCs16_b)
      `CHK("intRq", 1'b1, intRq)
      tick(1);
      wordCycle <= 1'b0;
      irqPending <= 1'b0;
      tick(2);
      @(negedge mclk);
      `CHK("ioCs16_b", 1'b1, ioCs16_b)
      `CHK("intRq", 1'b0, intRq)
      $display("pio test done");
   endtask : t_pio
   task automatic t_out;
      tick(1);
      udmaOut <= 1'b1;
      outReady <= 1'b1;
      tick(2);
      @(negedge mclk);
      `CHK("ddmardy", 1'b0, ioReady)
      tick(1);
      outReady <= 1'b0;
      tick(2);
      @(negedge mclk);
      `CHK("paused", 1'b1, ioReady)
      tick(1);
      outReady <= 1'b1;
      c0 = ins;
      host.hstrobe(16'h1234);
      host.hstrobe(16'hFEDC);
      @(negedge mclk);
      `CHK("edges", c0 + 2, ins)
      `CHK("inWord", 16'hFEDC, inWord)
      host.stop();
      @(negedge mclk);
      `CHK("stops", 1, stops)
      tick(1);
      udmaOut <= 1'b0;
      tick(2);
      @(negedge mclk);
      `CHK("idle", 1'b1, ioReady)
      $display("data-out test done");
   endtask : t_out
   task automatic t_in;
      host.ready(1'b1);
      udmaIn <= 1'b1;
      tick(4);
      @(negedge mclk);
      s = ioReady;
      tick(1);
      sendWord <= 16'h0F0F;
      sendValid <= 1'b1;
      tick(1);
      sendValid <= 1'b0;
      @(negedge mclk);
      `CHK("dstrobe", ~s, ioReady)
      `CHK("dataOut", 16'h0F0F, dataOut)
      `CHK("dataOutEn_b", 1'b0, dataOutEn_b)
      tick(3);
      @(negedge mclk);
      `CHK("held", ~s, ioReady)
      host.ready(1'b0);
      tick(4);
      sendValid <= 1'b1;
      @(negedge mclk);
      `CHK("sendTaken", 1'b0, sendTaken)
      `CHK("paused", ~s, ioReady)
      tick(1);
      sendValid <= 1'b0;
      host.ready(1'b1);
      tick(3);
      sendWord <= 16'hF0F0;
      sendValid <= 1'b1;
      tick(1);
      sendValid <= 1'b0;
      @(negedge mclk);
      `CHK("dstrobe", s, ioReady)
      `CHK("dataOut", 16'hF0F0, dataOut)
      tick(1);
      udmaIn <= 1'b0;
      tick(2);
      @(negedge mclk);
      `CHK("pio", 1'b1, ioReady)
      `CHK("dataOutEn_b", 1'b1, dataOutEn_b)
      $display("data-in test done");
   endtask : t_in
   task automatic t_pins;
      tick(1);
      diagDrive <= 1'b1;
      activeDrive <= 1'b1;
      diagIn <= 1'b0;
      activeIn <= 1'b0;
      irqPending <= 1'b1;
      tick(4);
      @(negedge mclk);
      `CHK("diag", 3'b001, {diagEn_b, diagOut, diagSeen})
      `CHK("active", 3'b001, {activeEn_b, activeOut, activeSeen})
      `CHK("isMaster", 1'b1, isMaster)
      `CHK("intRq", 1'b1, intRq)
      tick(1);
      {diagDrive, activeDrive, diagIn, activeIn} <= 4'h3;
      host.hreset(1'b0);
      tick(4);
      @(negedge mclk);
      `CHK("diag", 3'b100, {diagEn_b, diagOut, diagSeen})
      `CHK("active", 3'b100, {activeEn_b, activeOut, activeSeen})
      `CHK("intRq", 1'b0, intRq)
      host.hreset(1'b1);
      irqPending <= 1'b0;
      $display("pin test done");
   endtask : t_pins
   task automatic t_slave;
      tick(4);
      c0 = caps;
      cableSel <= 1'b1;
      rst_b <= 1'b0;
      tick(2);
      rst_b <= 1'b1;
      tick(6);
      @(negedge mclk);
      `CHK("isMaster", 1'b0, isMaster)
      `CHK("caps", c0, caps)
      `CHK("ioCs16_b", 1'b1, ioCs16_b)
      $display("slave test done");
   endtask : t_slave
   initial begin
      {rst_b, cableSel, udmaIn, udmaOut, wordCycle, irqPending, outReady, sendValid} = 8'h00;
      {diagDrive, activeDrive, diagIn, activeIn} = 4'h3;
      sendWord = 16'h0000;
      tick(16);
      rst_b <= 1'b1;
      tick(4);
      t_pio();
      t_out();
      t_in();
      t_pins();
      t_slave();
      close_out();
   end
   initial begin
      #20000;
      fails++;
      close_out();
   end
endmodule : tb
`default_nettype wire
